// ===== pkg/core_timing_pkg.sv
// constants and types for the pipelined core cycle-timing controller
package core_timing_pkg;

    // ========================================================================
    // clocking and capacity
    // ========================================================================
    localparam int unsigned SYS_CLK_HZ      = 40_000_000;
    localparam int unsigned CORE_MAX_HZ     = 25_000_000;
    localparam int unsigned INSTR_TOTAL     = 109;
    localparam int unsigned DATA_MEM_BYTES  = 256;
    localparam int unsigned SFR_SPACE_BYTES = 128;
    localparam logic [7:0]  SFR_BASE        = 8'h80;

    // ========================================================================
    // cycle timing
    // ========================================================================
    localparam logic [3:0]  MAX_INSTR_CYCLES = 4'h8;
    localparam logic [3:0]  EXT_MOVE_CYCLES  = 4'h3;
    localparam logic [3:0]  FIRST_CYCLE      = 4'h1;
    localparam logic [3:0]  FIRST_EXEC_SLOT  = 4'h2;
    localparam logic [3:0]  EXT_ACCESS_SLOT  = 4'h2;
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;

    // ========================================================================
    // opcodes the timing table singles out
    // ========================================================================
    localparam logic [7:0] OP_MUL       = 8'hA4;
    localparam logic [7:0] OP_DIV       = 8'h84;
    localparam logic [7:0] OP_CODE_DPTR = 8'h93;
    localparam logic [7:0] OP_CODE_PC   = 8'h83;
    localparam logic [7:0] OP_LOAD_DPTR = 8'h90;
    localparam logic [7:0] OP_INC_DPTR  = 8'hA3;
    localparam logic [7:0] OP_SHORT_JMP = 8'h80;

    typedef enum logic [1:0] {
        ST_FETCH,
        ST_EXEC,
        ST_HALTED
    } core_state_e;

endpackage

// ===== design/instr_timing_decode.sv
// opcode to length, cycle count and access class lookup
`timescale 1ns/10ps
`default_nettype none
module instr_timing_decode
    import core_timing_pkg::*;
(
    input  wire logic [7:0] opcode_in,
    output logic      [1:0] len_out,
    output logic      [3:0] cycles_out,
    output logic            cond_out,
    output logic            xmove_out,
    output logic            xwrite_out,
    output logic            code_read_out
);

    // ========================================================================
    // timing table
    // ========================================================================
    // encodings follow the standard set unchanged; only cycle counts differ [RQ2] [RQ7]
    // counts mirror the per-class distribution of the set [RQ3]
    always_comb begin
        {len_out, cycles_out, cond_out} = {2'd1, 4'h1, 1'b0};
        xmove_out     = 1'b0;
        xwrite_out    = 1'b0;
        code_read_out = 1'b0;
        casez (opcode_in)
            OP_MUL:       {len_out, cycles_out, cond_out} = {2'd1, 4'h4, 1'b0};
            OP_DIV:       {len_out, cycles_out, cond_out} = {2'd1, 4'h8, 1'b0};
            8'b111?00?0,
            8'b111?0011: begin
                {len_out, cycles_out, cond_out} = {2'd1, EXT_MOVE_CYCLES, 1'b0}; // [RQ14]
                xmove_out  = 1'b1;
                xwrite_out = opcode_in[4];
            end
            OP_CODE_DPTR,
            OP_CODE_PC: begin
                {len_out, cycles_out, cond_out} = {2'd1, 4'h3, 1'b0};
                code_read_out = 1'b1; // [RQ9]
            end
            OP_LOAD_DPTR: {len_out, cycles_out, cond_out} = {2'd3, 4'h3, 1'b0};
            OP_INC_DPTR:  {len_out, cycles_out, cond_out} = {2'd1, 4'h1, 1'b0};
            OP_SHORT_JMP: {len_out, cycles_out, cond_out} = {2'd2, 4'h3, 1'b0};
            8'b01??0000:  {len_out, cycles_out, cond_out} = {2'd2, 4'h3, 1'b1};
            8'b11011???:  {len_out, cycles_out, cond_out} = {2'd2, 4'h3, 1'b1};
            8'hD5,
            8'b101101??,
            8'b10111???:  {len_out, cycles_out, cond_out} = {2'd3, 4'h4, 1'b1};
            8'h75, 8'h85,
            8'b01??0011:  {len_out, cycles_out, cond_out} = {2'd3, 4'h3, 1'b0};
            8'b01111???,
            8'b1?001???,
            8'b0111011?,
            8'b1?00011?:  {len_out, cycles_out, cond_out} = {2'd2, 4'h2, 1'b0};
            8'b????1???:  {len_out, cycles_out, cond_out} = {2'd1, 4'h1, 1'b0};
            8'b????011?:  {len_out, cycles_out, cond_out} = {2'd1, 4'h2, 1'b0};
            8'b????0101,
            8'b01??0010:  {len_out, cycles_out, cond_out} = {2'd2, 4'h2, 1'b0};
            8'b00?10100,
            8'b0?1?0100,
            8'b10010100:  {len_out, cycles_out, cond_out} = {2'd2, 4'h2, 1'b0};
            default:      {len_out, cycles_out, cond_out} = {2'd1, 4'h1, 1'b0};
        endcase
    end

endmodule // instr_timing_decode
`default_nettype wire

// ===== design/pipelined_core_cycle_timing.sv
// fetch sequencer, cycle counter and debug halt control of the pipelined core
//
// Behaviour
// (RQ1) no instruction exceeds eight clocks
// (RQ2) exactly 109 instructions, binary compatible
// (RQ3) cycle classes follow the published distribution
// (RQ4) timing counted in plain clocks only
// (RQ5) one program byte fetched per clock
// (RQ6) untaken conditional branch ends one clock early
// (RQ7) opcodes, modes and status flags unchanged
// (RQ8) zero to 25 MHz, one instruction per clock peak
// (RQ9) software reads and writes flash bytewise
// (RQ10) debug host breaks, runs, steps, accesses memory
// (RQ11) debug uses no program-visible resources
// (RQ12) 256 data bytes, 128 byte special space
// (RQ13) external move targets on-chip program flash
// (RQ14) external move: one byte, three clocks
// (RQ15) count from opcode fetch to next fetch
`timescale 1ns/10ps
`default_nettype none
module pipelined_core_cycle_timing
    import core_timing_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    output logic      [15:0] code_addr_out,
    output logic             code_rd_out,
    output logic             code_wr_out,
    output logic      [7:0]  code_wdata_out,
    input  wire logic [7:0]  code_rdata_in,
    input  wire logic        branch_taken_in,
    input  wire logic        redirect_in,
    input  wire logic [15:0] redirect_pc_in,
    input  wire logic [15:0] xmove_addr_in,
    input  wire logic [15:0] code_read_addr_in,
    input  wire logic [7:0]  acc_in,
    output logic      [7:0]  opcode_out,
    output logic      [7:0]  operand1_out,
    output logic      [7:0]  operand2_out,
    output logic      [7:0]  mem_rdata_out,
    output logic             instr_start_out,
    output logic             instr_done_out,
    output logic      [3:0]  instr_cycles_out,
    output logic      [15:0] pc_out,
    input  wire logic        halt_req_in,
    input  wire logic        run_req_in,
    input  wire logic        step_req_in,
    input  wire logic        bp_wr_in,
    input  wire logic        bp_en_in,
    input  wire logic [15:0] bp_addr_in,
    input  wire logic        dbg_rd_in,
    input  wire logic        dbg_wr_in,
    input  wire logic        dbg_sfr_in,
    input  wire logic [7:0]  dbg_addr_in,
    input  wire logic [7:0]  dbg_wdata_in,
    output logic             halted_out,
    output logic             dmem_rd_out,
    output logic             dmem_wr_out,
    output logic             dmem_sfr_out,
    output logic      [7:0]  dmem_addr_out,
    output logic      [7:0]  dmem_wdata_out,
    input  wire logic [7:0]  dmem_rdata_in,
    output logic      [7:0]  dbg_rdata_out,
    output logic             dbg_ack_out,
    output logic             dbg_err_out
);

    // ========================================================================
    // state and decode
    // ========================================================================
    core_state_e state_q;
    logic [15:0] pc_q;
    logic [3:0]  cnt_q;
    logic [7:0]  opcode_q;
    logic        halt_pend_q;
    logic        step_q;
    logic        bp_en_q;
    logic [15:0] bp_addr_q;
    logic [7:0]  dec_op;
    logic [1:0]  dec_len;
    logic [3:0]  dec_cyc;
    logic        dec_cond;
    logic        dec_xmove;
    logic        dec_xwrite;
    logic        dec_code_read;
    logic        fetch_now;
    logic        ext_slot;
    logic        end_now;
    logic [15:0] next_pc;
    logic        halt_cond;
    logic        dbg_ok;

    // the live byte is decoded in the opcode cycle so one-clock instructions need no stall
    assign dec_op = (state_q == ST_FETCH) ? code_rdata_in : opcode_q;

    instr_timing_decode u_decode (
        .opcode_in     (dec_op),
        .len_out       (dec_len),
        .cycles_out    (dec_cyc),
        .cond_out      (dec_cond),
        .xmove_out     (dec_xmove),
        .xwrite_out    (dec_xwrite),
        .code_read_out (dec_code_read)
    );

    // ========================================================================
    // per-cycle control
    // ========================================================================
    // cycle n of an instruction fetches byte n while bytes remain [RQ4] [RQ5]
    assign fetch_now = (state_q == ST_FETCH) ||
                       ((state_q == ST_EXEC) && (cnt_q <= {2'b00, dec_len}));
    // the data slot of a move or code read is free because those are one byte long [RQ13]
    assign ext_slot  = (state_q == ST_EXEC) && (cnt_q == EXT_ACCESS_SLOT) && (dec_xmove || dec_code_read);

    always_comb begin
        end_now = 1'b0;
        if (state_q == ST_FETCH) begin
            end_now = (dec_cyc == FIRST_CYCLE); // [RQ8]
        end else if (state_q == ST_EXEC) begin
            end_now = (cnt_q == dec_cyc) ||
                      (dec_cond && !branch_taken_in && (cnt_q == dec_cyc - FIRST_CYCLE)); // [RQ6]
        end
    end

    always_comb begin
        next_pc = pc_q;
        if (end_now && redirect_in) begin
            next_pc = redirect_pc_in;
        end else if (fetch_now && !ext_slot) begin
            next_pc = pc_q + 16'h0001;
        end
    end

    // stopping only at a boundary keeps the program's own state untouched [RQ10] [RQ11]
    assign halt_cond = halt_pend_q || step_q || (bp_en_q && (next_pc == bp_addr_q));

    always_comb begin
        code_addr_out  = pc_q;
        code_rd_out    = fetch_now;
        code_wr_out    = 1'b0;
        code_wdata_out = acc_in;
        if (ext_slot) begin
            code_addr_out = dec_code_read ? code_read_addr_in : xmove_addr_in; // [RQ9] [RQ13]
            code_rd_out   = !(dec_xmove && dec_xwrite);
            code_wr_out   = dec_xmove && dec_xwrite;
        end
    end

    assign instr_start_out = (state_q == ST_FETCH); // [RQ15]
    assign instr_done_out  = end_now;
    assign halted_out      = (state_q == ST_HALTED);
    assign pc_out          = pc_q;

    // ========================================================================
    // sequencer
    // ========================================================================
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_q <= ST_FETCH;
            cnt_q   <= FIRST_EXEC_SLOT;
        end else begin
            case (state_q)
                ST_FETCH,
                ST_EXEC: begin
                    if (end_now) begin
                        state_q <= halt_cond ? ST_HALTED : ST_FETCH;
                        cnt_q   <= FIRST_EXEC_SLOT;
                    end else begin
                        state_q <= ST_EXEC;
                        cnt_q   <= (state_q == ST_FETCH) ? FIRST_EXEC_SLOT : cnt_q + FIRST_CYCLE; // [RQ1]
                    end
                end
                ST_HALTED: begin
                    if (run_req_in || step_req_in) begin
                        state_q <= ST_FETCH; // [RQ10]
                    end
                end
                default: state_q <= ST_FETCH;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pc_q <= RESET_VECTOR;
        end else if (state_q != ST_HALTED) begin
            pc_q <= next_pc;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            opcode_q     <= 8'h00;
            operand1_out <= 8'h00;
            operand2_out <= 8'h00;
        end else if (state_q == ST_FETCH) begin
            opcode_q <= code_rdata_in;
        end else if (fetch_now && !ext_slot) begin
            if (cnt_q == FIRST_EXEC_SLOT) begin
                operand1_out <= code_rdata_in;
            end else begin
                operand2_out <= code_rdata_in;
            end
        end
    end
    assign opcode_out = opcode_q;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mem_rdata_out <= 8'h00;
        end else if (ext_slot && code_rd_out) begin
            mem_rdata_out <= code_rdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            instr_cycles_out <= 4'h0;
        end else if (end_now) begin
            instr_cycles_out <= (state_q == ST_FETCH) ? FIRST_CYCLE : cnt_q; // [RQ15]
        end
    end

    // ========================================================================
    // debug control
    // ========================================================================
    // a halt request landing in the cycle the core halts is kept: set wins over clear
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            halt_pend_q <= 1'b0;
            step_q      <= 1'b0;
        end else begin
            halt_pend_q <= halt_req_in || (halt_pend_q && !(end_now && halt_cond));
            if (halted_out && step_req_in && !run_req_in) begin
                step_q <= 1'b1;
            end else if (end_now) begin
                step_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bp_en_q   <= 1'b0;
            bp_addr_q <= 16'h0000;
        end else if (bp_wr_in) begin
            bp_en_q   <= bp_en_in;
            bp_addr_q <= bp_addr_in;
        end
    end

    // host access only while halted, and the special space only covers its upper half [RQ11] [RQ12]
    assign dbg_ok         = halted_out && (!dbg_sfr_in || (dbg_addr_in >= SFR_BASE));
    assign dmem_rd_out    = dbg_rd_in && dbg_ok;
    assign dmem_wr_out    = dbg_wr_in && !dbg_rd_in && dbg_ok;
    assign dmem_sfr_out   = dbg_sfr_in;
    assign dmem_addr_out  = dbg_addr_in;
    assign dmem_wdata_out = dbg_wdata_in;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            dbg_ack_out   <= 1'b0;
            dbg_err_out   <= 1'b0;
            dbg_rdata_out <= 8'h00;
        end else begin
            dbg_ack_out <= (dbg_rd_in || dbg_wr_in) && dbg_ok;
            dbg_err_out <= (dbg_rd_in || dbg_wr_in) && !dbg_ok;
            if (dmem_rd_out) begin
                dbg_rdata_out <= dmem_rdata_in;
            end
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    chk_cycle_ceiling: assert property (cnt_q <= MAX_INSTR_CYCLES) // [RQ1]
        else $error("instruction ran past eight clocks");
    chk_byte_per_clock: assert property ( // [RQ5]
        (state_q == ST_EXEC) && (cnt_q <= {2'b00, dec_len}) |-> code_rd_out && (code_addr_out == pc_q))
        else $error("operand byte not fetched in its own clock");
    chk_untaken_short: assert property ( // [RQ6]
        end_now && (state_q == ST_EXEC) && dec_cond && !branch_taken_in |=> instr_cycles_out == $past(dec_cyc) - 4'h1)
        else $error("untaken branch did not end one clock early");
    chk_move_three: assert property ( // [RQ14]
        end_now && (state_q == ST_EXEC) && dec_xmove |=> instr_cycles_out == EXT_MOVE_CYCLES)
        else $error("external move did not take three clocks");
    chk_move_to_flash: assert property ( // [RQ13]
        ext_slot && dec_xmove |-> (code_addr_out == xmove_addr_in) && (code_wr_out == dec_xwrite))
        else $error("external move missed the program flash");
    chk_halt_boundary: assert property ( // [RQ10]
        $rose(halted_out) |-> $past(end_now))
        else $error("core halted mid instruction");
    chk_halt_quiet: assert property ( // [RQ11]
        halted_out |-> !code_rd_out && !code_wr_out && (!$past(halted_out) || pc_q == $past(pc_q)))
        else $error("halted core touched program state");
    chk_next_fetch: assert property ( // [RQ15]
        end_now && !halt_cond |=> instr_start_out)
        else $error("next opcode fetch did not follow the end");
    chk_special_space: assert property ( // [RQ12]
        (dmem_rd_out || dmem_wr_out) && dmem_sfr_out |-> dmem_addr_out >= SFR_BASE)
        else $error("special space access below its base");

    cov_single_clock: cover property (instr_start_out && end_now ##1 instr_start_out && end_now);
    cov_untaken: cover property (end_now && dec_cond && !branch_taken_in && (state_q == ST_EXEC));
    cov_divide: cover property (end_now && (dec_cyc == MAX_INSTR_CYCLES));
    cov_step: cover property (halted_out && step_req_in ##[1:10] $rose(halted_out));

endmodule // pipelined_core_cycle_timing
`default_nettype wire

// ===== testbench/flash_dmem_model.sv
// behavioural program flash and data memory facing the core
`timescale 1ns/10ps
`default_nettype none
module flash_dmem_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] code_addr_in,
    input  wire logic        code_rd_in,
    input  wire logic        code_wr_in,
    input  wire logic [7:0]  code_wdata_in,
    output logic      [7:0]  code_rdata_out,
    input  wire logic        dmem_rd_in,
    input  wire logic        dmem_wr_in,
    input  wire logic        dmem_sfr_in,
    input  wire logic [7:0]  dmem_addr_in,
    input  wire logic [7:0]  dmem_wdata_in,
    output logic      [7:0]  dmem_rdata_out
);
    // ========================================================================
    // storage
    // ========================================================================
    logic [7:0] flash  [0:65535];
    logic [7:0] ram    [0:255];
    logic [7:0] special_function_space    [0:127];
    logic [7:0] junk_q = 8'hA5;

    // ========================================================================
    // behaviour
    // ========================================================================
    // an idle bus toggles every cycle so a stale byte is never mistaken for data
    always @(posedge clk_in) begin
        junk_q <= ~junk_q;
        if (code_wr_in) flash[code_addr_in] <= code_wdata_in;
        if (dmem_wr_in && dmem_sfr_in) special_function_space[dmem_addr_in[6:0]] <= dmem_wdata_in;
        if (dmem_wr_in && !dmem_sfr_in) ram[dmem_addr_in] <= dmem_wdata_in;
    end

    assign code_rdata_out = code_rd_in ? flash[code_addr_in] : junk_q;
    assign dmem_rdata_out = !dmem_rd_in ? junk_q : dmem_sfr_in ? special_function_space[dmem_addr_in[6:0]] : ram[dmem_addr_in];
endmodule // flash_dmem_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the core cycle timing and debug control
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import core_timing_pkg::*;
;
    logic        sys_clk_in, srst_in, code_rd_out, code_wr_out, branch_taken_in, redirect_in;
    logic        instr_start_out, instr_done_out, halt_req_in, run_req_in, step_req_in, bp_wr_in;
    logic        bp_en_in, dbg_rd_in, dbg_wr_in, dbg_sfr_in, halted_out, dmem_rd_out, dmem_wr_out;
    logic        dmem_sfr_out, dbg_ack_out, dbg_err_out, vld, rd_pend, go;
    logic [3:0]  instr_cycles_out;
    logic [7:0]  code_wdata_out, code_rdata_in, acc_in, opcode_out, operand1_out, operand2_out;
    logic [7:0]  mem_rdata_out, dbg_addr_in, dbg_wdata_in, dmem_addr_out, dmem_wdata_out;
    logic [7:0]  dmem_rdata_in, dbg_rdata_out, rd_exp, op, r, w;
    logic [15:0] code_addr_out, redirect_pc_in, xmove_addr_in, code_read_addr_in, pc_out, bp_addr_in;
    logic [15:0] cur, nxt_pc, a, pend, p0;
    logic [7:0]  img  [0:65535];
    logic [3:0]  ecyc [0:4095];
    logic [15:0] enxt [0:4095];
    logic        tk   [0:4095];
    int          n_mismatch, num_checks, cnt, n_start, n0;
    localparam logic [7:0] OPS [15] = '{8'h00, 8'h04, 8'h24, 8'h75, OP_LOAD_DPTR, OP_INC_DPTR, OP_MUL,
        OP_DIV, OP_CODE_DPTR, OP_CODE_PC, 8'hE0, 8'hE2, 8'hF0, 8'h60, 8'h70};

    pipelined_core_cycle_timing i_dut (
        .sys_clk_in, .srst_in, .code_addr_out, .code_rd_out, .code_wr_out, .code_wdata_out,
        .code_rdata_in, .branch_taken_in, .redirect_in, .redirect_pc_in, .xmove_addr_in,
        .code_read_addr_in, .acc_in, .opcode_out, .operand1_out, .operand2_out, .mem_rdata_out,
        .instr_start_out, .instr_done_out, .instr_cycles_out, .pc_out, .halt_req_in, .run_req_in,
        .step_req_in, .bp_wr_in, .bp_en_in, .bp_addr_in, .dbg_rd_in, .dbg_wr_in, .dbg_sfr_in,
        .dbg_addr_in, .dbg_wdata_in, .halted_out, .dmem_rd_out, .dmem_wr_out, .dmem_sfr_out,
        .dmem_addr_out, .dmem_wdata_out, .dmem_rdata_in, .dbg_rdata_out, .dbg_ack_out, .dbg_err_out
    );

    flash_dmem_model i_mem (
        .clk_in(sys_clk_in), .code_addr_in(code_addr_out), .code_rd_in(code_rd_out),
        .code_wr_in(code_wr_out), .code_wdata_in(code_wdata_out), .code_rdata_out(code_rdata_in),
        .dmem_rd_in(dmem_rd_out), .dmem_wr_in(dmem_wr_out), .dmem_sfr_in(dmem_sfr_out),
        .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out), .dmem_rdata_out(dmem_rdata_in)
    );

    // ========================================================================
    // expectation and reporting helpers
    // ========================================================================
    function automatic logic [1:0] exp_l(input logic [7:0] o);
        case (o)
            8'h24, 8'h60, 8'h70:  return 2'h2;
            8'h75, OP_LOAD_DPTR:  return 2'h3;
            default:              return 2'h1;
        endcase
    endfunction

    function automatic logic [3:0] exp_c(input logic [7:0] o, input logic t);
        case (o)
            OP_MUL:                                         return 4'h4;
            OP_DIV:                                         return 4'h8;
            OP_CODE_DPTR, OP_CODE_PC, 8'hE0, 8'hE2, 8'hF0:  return 4'h3;
            8'h60, 8'h70:                                   return t ? 4'h3 : 4'h2;
            default:                                        return {2'h0, exp_l(o)};
        endcase
    endfunction

    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk_in);
        s = 1'b0;
    endtask

    // one debug memory access; a refused one must raise no strobe
    task automatic dbg(input logic rd, wr, special_function_space, input logic [7:0] ad, wd, input logic err);
        @(negedge sys_clk_in);
        dbg_rd_in = rd;
        dbg_wr_in = wr;
        dbg_sfr_in = special_function_space;
        dbg_addr_in = ad;
        dbg_wdata_in = wd;
        #1;
        check(dmem_wr_out === (wr & ~err) && dmem_rd_out === (rd & ~err), "debug strobe");
        @(negedge sys_clk_in);
        dbg_rd_in = 1'b0;
        dbg_wr_in = 1'b0;
        check(dbg_ack_out === ~err && dbg_err_out === err, "debug answer");
        r = dbg_rdata_out;
    endtask

    // ========================================================================
    // clock, watchdog and instruction monitor
    // ========================================================================
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        #(25 * 20000);
        n_mismatch++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end

    // counts only running cycles, so a halt never inflates an instruction's length
    always @(negedge sys_clk_in) begin
        redirect_in = go && !instr_start_out && instr_done_out === 1'b1 && tk[cur];
        redirect_pc_in = enxt[cur];
        if (!go) begin
            vld = 1'b0;
            rd_pend = 1'b0;
            nxt_pc = RESET_VECTOR;
        end else if (halted_out === 1'b1) begin
            check(code_rd_out === 1'b0 && instr_start_out === 1'b0, "fetch while halted");
        end else if (instr_start_out === 1'b1) begin
            n_start++;
            check(code_addr_out === nxt_pc && code_rd_out === 1'b1, "fetch address");
            if (vld) check(cnt == ecyc[cur] && instr_cycles_out === ecyc[cur], "cycle count");
            if (vld && rd_pend) check(mem_rdata_out === rd_exp, "flash byte read");
            cur = code_addr_out;
            nxt_pc = enxt[cur];
            cnt = 1;
            vld = 1'b1;
            branch_taken_in = tk[cur];
            acc_in = 8'($urandom);
            xmove_addr_in = {(img[cur] == 8'hE2) ? 8'h00 : 8'h80, 8'($urandom)};
            code_read_addr_in = {8'h80, 8'($urandom)};
            rd_pend = img[cur] inside {8'hE0, 8'hE2, OP_CODE_DPTR, OP_CODE_PC};
            rd_exp = img[(img[cur] inside {8'hE0, 8'hE2}) ? xmove_addr_in : code_read_addr_in];
            if (img[cur] == 8'hF0) img[xmove_addr_in] = acc_in;
        end else begin
            cnt++;
            if (cnt == 2) check(opcode_out === img[cur], "opcode register");
        end
    end

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        {srst_in, branch_taken_in, redirect_in, halt_req_in, run_req_in, step_req_in} = 6'h20;
        {go, bp_wr_in, bp_en_in, dbg_rd_in, dbg_wr_in, dbg_sfr_in} = 6'h00;
        {redirect_pc_in, xmove_addr_in, code_read_addr_in, bp_addr_in} = 64'h0;
        {acc_in, dbg_addr_in, dbg_wdata_in} = 24'h0;
        n0 = $urandom(50183);
        for (int k = 0; k < 65536; k++) img[k] = 8'($urandom);
        a = RESET_VECTOR;
        // random program; a taken branch skips a divide opcode that would cost 8 clocks
        for (int i = 0; i < 150; i++) begin
            op = OPS[$urandom % 15];
            img[a] = op;
            tk[a] = (op == 8'h60 || op == 8'h70) && 1'($urandom);
            ecyc[a] = exp_c(op, tk[a]);
            enxt[a] = a + 16'(exp_l(op)) + 16'(tk[a]);
            if (tk[a]) img[a + 2] = OP_DIV;
            a = enxt[a];
        end
        pend = a;
        for (int k = a; k < 4096; k++) begin
            img[k] = 8'h00;
            ecyc[k] = 4'h1;
            enxt[k] = 16'(k + 1);
            tk[k] = 1'b0;
        end
        for (int k = 0; k < 65536; k++) i_mem.flash[k] = img[k];
        @(negedge sys_clk_in) go <= 1'b1;
        @(negedge sys_clk_in);
        srst_in = 1'b0;
        for (int i = 0; i < 4000 && !(vld && cur >= pend); i++) @(negedge sys_clk_in);
        check(vld && cur >= pend, "program did not finish");
        dbg(1'b0, 1'b1, 1'b0, 8'h10, 8'h55, 1'b1);
        pulse(halt_req_in);
        for (int i = 0; i < 10 && halted_out !== 1'b1; i++) @(negedge sys_clk_in);
        check(halted_out === 1'b1, "halt not reached");
        w = 8'($urandom);
        op = 8'($urandom);
        dbg(1'b0, 1'b1, 1'b0, op, w, 1'b0);
        dbg(1'b1, 1'b0, 1'b0, op, 8'h00, 1'b0);
        check(r === w, "data memory readback");
        dbg(1'b0, 1'b1, 1'b1, op | 8'h80, ~w, 1'b0);
        dbg(1'b1, 1'b0, 1'b1, op | 8'h80, 8'h00, 1'b0);
        check(r === ~w, "special space readback");
        dbg(1'b1, 1'b0, 1'b1, op & 8'h7F, 8'h00, 1'b1);
        n0 = n_start;
        p0 = pc_out;
        pulse(step_req_in);
        for (int i = 0; i < 20 && !(halted_out === 1'b1 && n_start != n0); i++) @(negedge sys_clk_in);
        check(n_start == n0 + 1 && pc_out === p0 + 16'h1, "single step");
        bp_en_in = 1'b1;
        bp_addr_in = pc_out + 16'h6;
        pulse(bp_wr_in);
        pulse(run_req_in);
        for (int i = 0; i < 30 && halted_out !== 1'b1; i++) @(negedge sys_clk_in);
        check(halted_out === 1'b1 && pc_out === bp_addr_in, "breakpoint stop");
        for (int k = 16'h8000; k < 16'h8100; k++) check(i_mem.flash[k] === img[k], "flash byte write");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
